/* File: mfi_cfg.svh */
// constants for the multi-function input decoder
`ifndef MFI_CFG_SVH
`define MFI_CFG_SVH
`define MFI_CLK_HZ          40000000
`define MFI_SH_TIME_MS      100
`define MFI_SH_CYCLES       ((`MFI_CLK_HZ / 1000) * `MFI_SH_TIME_MS)
`define MFI_FSTOP_DEF_DS    100
`define MFI_FN_HOLD_RAMP    8'h0A
`define MFI_FN_UP           8'h10
`define MFI_FN_DOWN         8'h11
`define MFI_FN_LOCKOUT      8'h1B
`define MFI_FN_SAMPLE_HOLD  8'h1E
`define MFI_FN_EXT_FAULT_LO 8'h20
`define MFI_FN_EXT_FAULT_HI 8'h2F
`define MFI_FN_INTEG_RESET  8'h30
`define MFI_FN_OFFSET_LO    8'h44
`define MFI_FN_OFFSET_HI    8'h46
`define MFI_FN_UPDN2_LO     8'h75
`define MFI_FN_UPDN2_HI     8'h76
`define MFI_ADR_CTRL        8'h00
`define MFI_ADR_STATUS      8'h04
`define MFI_ADR_IRQ_STAT    8'h08
`define MFI_ADR_IRQ_CLR     8'h0C
`define MFI_ADR_IRQ_EN      8'h10
`define MFI_ADR_FREQ_REF    8'h14
`define MFI_ADR_FSTOP       8'h18
`define MFI_ADR_FUNC_BASE   8'h20
`define MFI_CTRL_RESET      32'h0000_0000
`define MFI_IRQ_EXT_FAULT   0
`define MFI_IRQ_CONFLICT    1
`define MFI_IRQ_SAMPLE      2
`define MFI_IRQ_ALARM       3
`define MFI_IRQ_LOCK_REJ    4
`define MFI_IRQ_BITS        5
`endif

/* File: mfi_pkg.sv */
// types for the multi-function input decoder
package mfi_pkg;
	typedef enum logic [1:0] {MFI_STOP_RAMP, MFI_STOP_COAST, MFI_STOP_FAST, MFI_STOP_ALARM}
		mfi_stop_e;
	typedef struct packed {
		logic       active;
		logic [2:0] terminal;
		mfi_stop_e  reaction;
	} mfi_fault_s;
	typedef struct packed {
		logic [7:0]  adr;
		logic [31:0] dat;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} mfi_wb_req_s;
endpackage : mfi_pkg

/* File: mfi_ext_fault.sv */
// one contact input decoded against the external fault codes
`timescale 1ns/1ps
`default_nettype none
module mfi_ext_fault
	import mfi_pkg::*;
(
	// configuration and contact
	input  wire logic [7:0] func_code,
	input  wire logic       contact_closed,
	input  wire logic       running,
	// decoded result
	output logic            fault,
	output mfi_pkg::mfi_stop_e reaction
);
	`include "mfi_cfg.svh"
	logic is_ext;
	logic level_hit;
	logic armed;

	// code range, polarity, detection window
	always_comb
	begin
		is_ext    = (func_code >= `MFI_FN_EXT_FAULT_LO) && (func_code <= `MFI_FN_EXT_FAULT_HI);
		level_hit = func_code[0] ? !contact_closed : contact_closed;
		armed     = !func_code[1] || running;
		fault     = is_ext && level_hit && armed;
		reaction  = mfi_stop_e'(func_code[3:2]);
	end
endmodule : mfi_ext_fault
`default_nettype wire

/* File: mfi_decode.sv */
// multi-function contact input decoder with wishbone registers
//
// Summary of operation
// - lockout open rejects writes except frequency reference, interrupt clear and interrupt enable
// - lockout closed lets parameter writes through
// - reads always allowed regardless of lockout
// - sample/hold held 100 ms captures analog
// - release before 100 ms leaves reference unchanged
// - sample/hold with conflicting codes flags error
// - reference clears to zero at power-up
// - codes 20 to 2F are external faults
// - fault indication carries terminal index
// - even code normally open, odd normally closed
// - some codes always detected, others during run
// - always-detected faults monitored from power-up
// - code groups pick ramp, coast, fast, alarm
// - integral reset input holds integrator at zero
// - fast stop uses fast stop time setting
`timescale 1ns/1ps
`default_nettype none
`include "mfi_cfg.svh"
module mfi_decode
	import mfi_pkg::*;
#(
	parameter int N_IN   = 7,
	parameter int AW     = 12,
	parameter int SH_CYC = `MFI_SH_CYCLES
)
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              arst_n,
	// wishbone slave
	input  wire mfi_pkg::mfi_wb_req_s wb_req,
	output logic [31:0]            wb_dat_o,
	output logic                   wb_ack_o,
	// contacts and drive state
	input  wire logic [N_IN-1:0]   contact_closed,
	input  wire logic              running,
	input  wire logic [1:0]        analog_sel,
	input  wire logic [AW-1:0]     analog_input_first,
	input  wire logic [AW-1:0]     analog_input_second,
	input  wire logic [AW-1:0]     analog_input_third,
	// drive outputs
	output logic [AW-1:0]          freq_ref,
	output logic                   config_conflict_error,
	output logic                   external_fault_indicator,
	output logic [2:0]             fault_terminal,
	output mfi_pkg::mfi_stop_e     stop_method,
	output logic                   stop_request,
	output logic                   alarm,
	output logic [15:0]            fast_stop_time,
	output logic                   pid_integ_clear,
	output logic                   irq
);

	// refuse parameter values the logic cannot serve
	if (N_IN < 1 || N_IN > 7 || AW < 1 || AW > 32 || SH_CYC < 1)
	begin : g_bad_param
		$error("mfi_decode: unsupported parameter values");
	end

	localparam int CW = $clog2(SH_CYC + 1);

	logic [7:0]         func_code [N_IN];
	logic [N_IN-1:0]    ext_hit;
	mfi_stop_e          ext_react [N_IN];
	logic               lock_active;
	logic               sh_active;
	logic               conflict_code;
	logic [CW-1:0]      sh_count;
	logic               sh_fired;
	logic               sample_pulse;
	logic [AW-1:0]      analog_pick;
	logic [`MFI_IRQ_BITS-1:0] irq_stat;
	logic [`MFI_IRQ_BITS-1:0] irq_en;
	logic [`MFI_IRQ_BITS-1:0] irq_set;
	logic [`MFI_IRQ_BITS-1:0] irq_clr;
	logic               fault_found;
	logic [2:0]         fault_idx;
	mfi_stop_e          fault_react;
	logic               wb_go;
	logic               wr_go;
	logic               is_func_adr;
	logic [2:0]         func_idx;
	logic               wr_blocked;

	// true when a code belongs to the sample/hold conflict set
	function automatic logic conflicts(input logic [7:0] c);
		conflicts = (c == `MFI_FN_HOLD_RAMP) || (c == `MFI_FN_UP) || (c == `MFI_FN_DOWN)
			|| (c >= `MFI_FN_OFFSET_LO && c <= `MFI_FN_OFFSET_HI)
			|| (c >= `MFI_FN_UPDN2_LO && c <= `MFI_FN_UPDN2_HI);
	endfunction : conflicts

	// one fault decoder per terminal
	for (genvar i = 0; i < N_IN; i++)
	begin : g_term
		mfi_ext_fault u_ext (
			.func_code      (func_code[i]),
			.contact_closed (contact_closed[i]),
			.running        (running),
			.fault          (ext_hit[i]),
			.reaction       (ext_react[i])
		);
	end

	// function-wide scans over all terminals
	always_comb
	begin
		lock_active   = 1'b0;
		sh_active     = 1'b0;
		conflict_code = 1'b0;
		pid_integ_clear = 1'b0;
		fault_found   = 1'b0;
		fault_idx     = 3'h0;
		fault_react   = MFI_STOP_RAMP;
		for (int i = 0; i < N_IN; i++)
		begin
			if (func_code[i] == `MFI_FN_LOCKOUT && !contact_closed[i])
				lock_active = 1'b1;
			if (func_code[i] == `MFI_FN_SAMPLE_HOLD && contact_closed[i])
				sh_active = 1'b1;
			if (conflicts(func_code[i]))
				conflict_code = 1'b1;
			if (func_code[i] == `MFI_FN_INTEG_RESET && contact_closed[i])
				pid_integ_clear = 1'b1;
			if (ext_hit[i] && !fault_found)
			begin
				fault_found = 1'b1;
				fault_idx   = 3'(i + 1);
				fault_react = ext_react[i];
			end
		end
	end

	// sample/hold present with any conflicting code
	always_comb
	begin
		config_conflict_error = 1'b0;
		for (int i = 0; i < N_IN; i++)
			if (func_code[i] == `MFI_FN_SAMPLE_HOLD && conflict_code)
				config_conflict_error = 1'b1;
	end

	// qualification timer, restarts on release
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sh_count <= '0;
			sh_fired <= 1'b0;
		end
		else if (!sh_active)
		begin
			sh_count <= '0;
			sh_fired <= 1'b0;
		end
		else if (sh_count < CW'(SH_CYC))
			sh_count <= sh_count + 1'b1;
		else
			sh_fired <= 1'b1;
	end
	assign sample_pulse = sh_active && (sh_count == CW'(SH_CYC)) && !sh_fired;

	// analog source selection
	always_comb
	begin
		case (analog_sel)
			2'h1:    analog_pick = analog_input_second;
			2'h2:    analog_pick = analog_input_third;
			default: analog_pick = analog_input_first;
		endcase
	end

	// wishbone decode
	assign wb_go       = wb_req.cyc && wb_req.stb && !wb_ack_o;
	assign wr_go       = wb_go && wb_req.we;
	assign is_func_adr = (wb_req.adr >= `MFI_ADR_FUNC_BASE)
		&& (wb_req.adr < 8'(`MFI_ADR_FUNC_BASE + 4 * N_IN)) && (wb_req.adr[1:0] == 2'h0);
	assign func_idx    = 3'((wb_req.adr - `MFI_ADR_FUNC_BASE) >> 2);
	assign wr_blocked  = lock_active && (wb_req.adr != `MFI_ADR_FREQ_REF)
		&& (wb_req.adr != `MFI_ADR_IRQ_CLR) && (wb_req.adr != `MFI_ADR_IRQ_EN);

	// frequency reference: sample, software write, zero at power-up
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			freq_ref <= '0;
		else if (sample_pulse)
			freq_ref <= analog_pick;
		else if (wr_go && wb_req.adr == `MFI_ADR_FREQ_REF && wb_req.sel[0])
			freq_ref <= wb_req.dat[AW-1:0];
	end

	// lockable parameters: function codes and fast stop time
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < N_IN; i++)
				func_code[i] <= 8'h00;
			fast_stop_time <= 16'(`MFI_FSTOP_DEF_DS);
		end
		else if (wr_go && !wr_blocked)
		begin
			if (is_func_adr && wb_req.sel[0])
				func_code[func_idx] <= wb_req.dat[7:0];
			if (wb_req.adr == `MFI_ADR_FSTOP && wb_req.sel[0])
				fast_stop_time[7:0] <= wb_req.dat[7:0];
			if (wb_req.adr == `MFI_ADR_FSTOP && wb_req.sel[1])
				fast_stop_time[15:8] <= wb_req.dat[15:8];
		end
	end

	// interrupt enable
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_en <= '0;
		else if (wr_go && wb_req.adr == `MFI_ADR_IRQ_EN && wb_req.sel[0])
			irq_en <= wb_req.dat[`MFI_IRQ_BITS-1:0];
	end

	// sticky status, set wins over clear
	always_comb
	begin
		irq_set = '0;
		irq_set[`MFI_IRQ_EXT_FAULT] = fault_found && fault_react != MFI_STOP_ALARM;
		irq_set[`MFI_IRQ_CONFLICT]  = config_conflict_error;
		irq_set[`MFI_IRQ_SAMPLE]    = sample_pulse;
		irq_set[`MFI_IRQ_ALARM]     = fault_found && fault_react == MFI_STOP_ALARM;
		irq_set[`MFI_IRQ_LOCK_REJ]  = wr_go && wr_blocked;
		irq_clr = (wr_go && wb_req.adr == `MFI_ADR_IRQ_CLR && wb_req.sel[0])
			? wb_req.dat[`MFI_IRQ_BITS-1:0] : '0;
	end
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			irq_stat <= '0;
		else
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
	end
	assign irq = |(irq_stat & irq_en);

	// registered fault report toward the sequencer, follows the contacts each cycle
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			external_fault_indicator <= 1'b0;
			fault_terminal           <= 3'h0;
			stop_method              <= MFI_STOP_RAMP;
			stop_request             <= 1'b0;
			alarm                    <= 1'b0;
		end
		else
		begin
			external_fault_indicator <= fault_found;
			fault_terminal           <= fault_found ? fault_idx : 3'h0;
			stop_method              <= fault_react;
			stop_request             <= fault_found && fault_react != MFI_STOP_ALARM;
			alarm                    <= fault_found && fault_react == MFI_STOP_ALARM;
		end
	end

	// read data and ack, reads never locked
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_go;
			wb_dat_o <= 32'h0000_0000;
			if (wb_go && !wb_req.we)
			begin
				if (wb_req.adr == `MFI_ADR_CTRL)
					wb_dat_o <= `MFI_CTRL_RESET;
				else if (wb_req.adr == `MFI_ADR_STATUS)
					wb_dat_o <= {22'h0, fault_react, fault_idx, fault_found, sh_active,
						lock_active, config_conflict_error, pid_integ_clear};
				else if (wb_req.adr == `MFI_ADR_IRQ_STAT)
					wb_dat_o <= 32'(irq_stat);
				else if (wb_req.adr == `MFI_ADR_IRQ_EN)
					wb_dat_o <= 32'(irq_en);
				else if (wb_req.adr == `MFI_ADR_FREQ_REF)
					wb_dat_o <= 32'(freq_ref);
				else if (wb_req.adr == `MFI_ADR_FSTOP)
					wb_dat_o <= 32'(fast_stop_time);
				else if (is_func_adr)
					wb_dat_o <= 32'(func_code[func_idx]);
			end
		end
	end
endmodule : mfi_decode
`default_nettype wire

/* File: mfi_decode_properties.sv */
// port assertions for the input decoder
`timescale 1ns/1ps
`default_nettype none
module mfi_decode_properties
	import mfi_pkg::*;
#(
	parameter int AW = 12
)
(
	// clock, reset and bus
	input wire logic                  clk,
	input wire logic                  arst_n,
	input wire mfi_pkg::mfi_wb_req_s  wb_req,
	input wire logic [31:0]           wb_dat_o,
	input wire logic                  wb_ack_o,
	// drive outputs
	input wire logic [AW-1:0]         freq_ref,
	input wire logic                  external_fault_indicator,
	input wire logic [2:0]            fault_terminal,
	input wire mfi_pkg::mfi_stop_e    stop_method,
	input wire logic                  stop_request,
	input wire logic                  alarm,
	input wire logic [15:0]           fast_stop_time
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// request taken, then reads of chosen places
	sequence take_s;
		wb_req.cyc && wb_req.stb && !wb_ack_o;
	endsequence
	sequence rd_s(logic [7:0] a);
		take_s ##0 (!wb_req.we && wb_req.adr == a);
	endsequence
	ack_answer_a: assert property (take_s |=> wb_ack_o) else $error("ack missing");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	clear_read_a: assert property (rd_s(8'h0C) |=> wb_dat_o == 32'h0)
		else $error("clear register read not zero");
	fstop_read_a: assert property (rd_s(8'h18) |=> wb_dat_o[15:0] == fast_stop_time)
		else $error("fast stop read mismatch");
	reset_val_a: assert property ($rose(arst_n) |-> fast_stop_time == 16'h0064
		&& freq_ref == '0) else $error("bad value after reset");
	alarm_kind_a: assert property (alarm |-> stop_method == MFI_STOP_ALARM && !stop_request)
		else $error("alarm with stop");
	stop_kind_a: assert property (stop_request |-> stop_method != MFI_STOP_ALARM
		&& external_fault_indicator) else $error("stop without fault");
	fault_term_a: assert property (external_fault_indicator |-> fault_terminal != 3'h0)
		else $error("fault without terminal");
endmodule : mfi_decode_properties
bind mfi_decode mfi_decode_properties #(.AW(AW)) u_props (.clk(clk), .arst_n(arst_n),
	.wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .freq_ref(freq_ref),
	.external_fault_indicator(external_fault_indicator), .fault_terminal(fault_terminal),
	.stop_method(stop_method), .stop_request(stop_request), .alarm(alarm),
	.fast_stop_time(fast_stop_time));
`default_nettype wire

/* File: mfi_field_dev.sv */
// contact model of the field devices
`timescale 1ns/1ps
`default_nettype none
module mfi_field_dev #(
	parameter int N_IN = 7
)
(
	// device state and wiring
	input  wire logic [N_IN-1:0] tripped,
	input  wire logic [N_IN-1:0] nc_wired,
	// contacts seen by the drive
	output logic      [N_IN-1:0] contact_closed
);
	// n.c. wiring opens on trip, n.o. closes
	assign contact_closed = tripped ^ nc_wired;
endmodule : mfi_field_dev
`default_nettype wire

/* File: tb.sv */
// self-checking bench for the input decoder
`timescale 1ns/1ps
`default_nettype none
`include "mfi_cfg.svh"
module tb;
	import mfi_pkg::*;
	logic        clk = 1'b0, arst_n = 1'b0, running = 1'b0;
	logic        ack, cfe, efi, sreq, alm, pic, irq;
	mfi_wb_req_s req = '0;
	logic [31:0] dat, rs = 32'h47;
	logic [1:0]  asel = 2'h0;
	logic [11:0] a1 = '0, a2 = '0, a3 = '0, fref, ex;
	logic [6:0]  trip = '0, ncw = '0, cc;
	logic [2:0]  fterm;
	logic [15:0] fst;
	mfi_stop_e   smeth;
	logic [32:0] q[$];
	logic [7:0]  cf[8] = '{8'h0A, 8'h10, 8'h11, 8'h44, 8'h45, 8'h46, 8'h75, 8'h76};
	int          fails = 0, comparisons = 0;
	mfi_decode #(.N_IN(7), .AW(12), .SH_CYC(20)) dut (.clk(clk), .arst_n(arst_n),
		.wb_req(req), .wb_dat_o(dat), .wb_ack_o(ack), .contact_closed(cc),
		.running(running), .analog_sel(asel), .analog_input_first(a1),
		.analog_input_second(a2), .analog_input_third(a3), .freq_ref(fref),
		.config_conflict_error(cfe), .external_fault_indicator(efi), .fault_terminal(fterm),
		.stop_method(smeth), .stop_request(sreq), .alarm(alm), .fast_stop_time(fst),
		.pid_integ_clear(pic), .irq(irq));
	mfi_field_dev #(.N_IN(7)) u_dev (.tripped(trip), .nc_wired(ncw), .contact_closed(cc));
	// clock
	initial forever #12.5 clk = ~clk;
	// compare and count
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// one bus cycle; a read notes its expected data
	task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		req <= '{adr: a, dat: d, sel: 4'hF, we: w, cyc: 1'b1, stb: 1'b1};
		q.push_back({!w, d});
		do @(posedge clk); while (ack !== 1'b1);
		req <= '0;
	endtask : wb
	// contact pattern held for some edges, then settle
	task automatic put(input logic [6:0] t, input int n);
		trip <= t;
		repeat (n) @(posedge clk);
	endtask : put
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// watcher retires the oldest note at each ack
	always @(posedge clk)
	begin
		if (ack === 1'b1 && q.size() > 0)
		begin
			if (q[0][32])
				chk("read data", q[0][31:0], dat);
			void'(q.pop_front());
		end
	end
	// verdict
	task automatic wrap_up();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	// hang guard
	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		wrap_up();
	end
	// test sequence
	initial
	begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		wb(`MFI_ADR_FSTOP, 32'h64, 1'b0);
		wb(`MFI_ADR_FREQ_REF, 32'h0, 1'b0);
		wb(8'h80, 32'hFFFF_FFFF, 1'b1);
		wb(8'h80, 32'h0, 1'b0);
		$display("test reset done");
		for (int c = 32; c < 48; c++)
		begin
			ncw <= {5'h0, c[0], 1'b0};
			running <= 1'b1;
			wb(8'h24, c, 1'b1);
			put(7'h00, 3);
			chk("quiet", 32'h0, efi | alm | sreq);
			running <= 1'b0;
			put(7'h02, 3);
			chk("idle fault", !c[1], efi | alm);
			running <= 1'b1;
			put(7'h02, 3);
			chk("kind", {c[3:2] != 2'h3, c[3:2] == 2'h3, c[3:2]}, {sreq, alm, smeth});
			if (c[3:2] != 2'h3)
				chk("terminal", 32'h2, fterm);
		end
		running <= 1'b0;
		put(7'h00, 3);
		$display("test faults done");
		wb(8'h2C, 32'h10, 1'b1);
		chk("conflict", 32'h0, cfe);
		wb(8'h28, 32'h1E, 1'b1);
		foreach (cf[i])
		begin
			wb(8'h2C, cf[i], 1'b1);
			chk("conflict", 32'h1, cfe);
		end
		wb(8'h2C, 32'h0, 1'b1);
		rs = xs(rs);
		a1 <= rs[11:0];
		a2 <= rs[23:12];
		a3 <= rs[31:20] ^ 12'hA5A;
		asel <= rs[5:4];
		ex = (rs[5:4] == 2'h1) ? rs[23:12] : (rs[5:4] == 2'h2) ? rs[31:20] ^ 12'hA5A : rs[11:0];
		put(7'h04, 15);
		put(7'h00, 3);
		chk("short hold", 32'h0, fref);
		put(7'h04, 10);
		put(7'h00, 3);
		chk("split hold", 32'h0, fref);
		put(7'h04, 25);
		put(7'h00, 3);
		chk("sampled", ex, fref);
		wb(8'h30, 32'h30, 1'b1);
		put(7'h10, 3);
		chk("integ clear", 32'h1, pic);
		put(7'h00, 3);
		chk("integ free", 32'h0, pic);
		$display("test sample done");
		wb(`MFI_ADR_IRQ_EN, 32'h0, 1'b1);
		chk("irq masked", 32'h0, irq);
		wb(`MFI_ADR_IRQ_EN, 32'h1, 1'b1);
		chk("irq raised", 32'h1, irq);
		wb(`MFI_ADR_IRQ_STAT, 32'h0F, 1'b0);
		wb(`MFI_ADR_IRQ_CLR, 32'h1F, 1'b1);
		wb(`MFI_ADR_IRQ_CLR, 32'h0, 1'b0);
		chk("irq cleared", 32'h0, irq);
		$display("test irq done");
		put(7'h01, 1);
		wb(8'h20, 32'h1B, 1'b1);
		wb(`MFI_ADR_FSTOP, 32'h37, 1'b1);
		wb(`MFI_ADR_FSTOP, 32'h37, 1'b0);
		chk("fast stop", 32'h37, fst);
		put(7'h00, 1);
		wb(`MFI_ADR_FSTOP, 32'h4D, 1'b1);
		wb(`MFI_ADR_FSTOP, 32'h37, 1'b0);
		chk("fast stop", 32'h37, fst);
		wb(8'h24, 32'h0, 1'b1);
		wb(8'h24, 32'h2F, 1'b0);
		wb(`MFI_ADR_FREQ_REF, 32'h123, 1'b1);
		wb(`MFI_ADR_FREQ_REF, 32'h123, 1'b0);
		wb(`MFI_ADR_IRQ_STAT, 32'h10, 1'b0);
		$display("test lockout done");
		// power cycle with the drive stopped: written reference and settings start over
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		wb(`MFI_ADR_FREQ_REF, 32'h0, 1'b0);
		wb(`MFI_ADR_FSTOP, 32'h64, 1'b0);
		chk("reset reference", 32'h0, fref);
		$display("test power cycle done");
		wrap_up();
	end
endmodule : tb
`default_nettype wire
